//--- verilog/config_pkg.sv
// shared constants, carriers and decode for the system configuration block
// assumes one 10 MHz clock and an asynchronous active-high processor reset
package config_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offset (byte address, one aligned word)
    localparam logic [ADDR_W-1:0] SYS_CONFIG_OFFSET = 8'h00;

    // field positions inside system_configuration
    localparam int MEM_SEL_BIT = 0;
    localparam int IF_SEL_BIT = 1;

    // reset values of the state before the boot-mode load
    localparam logic MEM_SEL_RESET = 1'b0;
    localparam logic IF_SEL_RESET = 1'b0;
    localparam logic LOAD_PENDING_RESET = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // latched boot-mode codes that place SDRAM in chip-enable area 0
    localparam logic [3:0] BOOT_SDRAM_AREA0_NO_BOOT = 4'h1;
    localparam logic [3:0] BOOT_SDRAM_AREA0_FLASH_BOOT = 4'h9;

    // depth of the pin synchroniser
    localparam int SYNC_STAGES = 2;

    // one register bus request, as seen in the cycle of the strobe
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    // routing of the external synchronous memories
    typedef struct packed {
        logic sbsram_area0_en;
        logic sdram_area0_en;
        logic sdram_area2_en;
    } mem_route_s;

    // all memories off, held until the boot-mode load is done
    localparam mem_route_s ROUTE_RESET = 3'b000;

    // true for the two boot configurations with SDRAM in area 0
    function automatic logic sdram_boot(input logic [3:0] code);
        sdram_boot = (code == BOOT_SDRAM_AREA0_NO_BOOT) ||
                     (code == BOOT_SDRAM_AREA0_FLASH_BOOT);
    endfunction : sdram_boot

    // routing for a given memory type select value
    function automatic mem_route_s route_for(input logic sel);
        mem_route_s r;
        r.sbsram_area0_en = ~sel;
        r.sdram_area0_en = sel;
        r.sdram_area2_en = sel;
        route_for = r;
    endfunction : route_for

endpackage : config_pkg

//--- verilog/pin_sync.sv
// two-stage synchroniser for a group of board pins
// assumes the pins are quasi-static; no reset, so it tracks the pins in reset
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input wire logic clk,
    // asynchronous pins
    input wire logic [WIDTH-1:0] pin_in,
    // synchronised copy
    output logic [WIDTH-1:0] pin_out
);
    // stage flops; stage 0 is read only by stage 1
    logic [WIDTH-1:0] stage [config_pkg::SYNC_STAGES];

    // no reset here on purpose: the pins must be seen while reset is held
    always_ff @(posedge clk) begin
        stage[0] <= pin_in;
        for (int i = 1; i < config_pkg::SYNC_STAGES; i++) begin
            stage[i] <= stage[i-1];
        end
    end

    assign pin_out = stage[config_pkg::SYNC_STAGES-1];
endmodule : pin_sync
`default_nettype wire

//--- verilog/config_reg_port.sv
// register port: address decode, write hit and registered read data
// assumes one-cycle strobes from a master on the same clock
`timescale 1ns/10ps
`default_nettype none
module config_reg_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus request
    input wire config_pkg::reg_req_s req,
    // current field values
    input wire logic mem_sel,
    input wire logic if_sel,
    // decoded write to the configuration word
    output logic wr_hit,
    // read data, valid the cycle after the read strobe
    output logic [config_pkg::DATA_W-1:0] rdata
);
    logic hit; // address matches the configuration word
    logic [config_pkg::DATA_W-1:0] next_rdata; // next read data

    assign hit = (req.addr == config_pkg::SYS_CONFIG_OFFSET);
    assign wr_hit = req.wr & hit;

    // read mux; bits 2 and up and unmapped addresses read as zero
    always_comb begin
        next_rdata = '0;
        if (req.rd && hit) begin
            next_rdata[config_pkg::MEM_SEL_BIT] = mem_sel;
            next_rdata[config_pkg::IF_SEL_BIT] = if_sel;
        end
    end

    // read data stands for exactly one cycle, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= config_pkg::RDATA_RESET;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : config_reg_port
`default_nettype wire

//--- verilog/board_system_config.sv
// board system configuration register and memory routing
// assumes clk at 10 MHz and rst as the processor reset (async, active high)
// Function
// - select 0: SBSRAM area0 on, SDRAM off
// - select 1: SDRAM areas 0,2 on, SBSRAM off
// - reset default follows latched boot mode
// - software may rewrite select anytime, routing follows
// - switch captured at reset release, later ignored
// - interface bit: 0 serial, 1 cell interface
// - no cell interface variant reads 0
// - boot codes 1 and 9 mean SDRAM
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module board_system_config #(
    parameter bit HAS_MEM_SELECT = 1'b1, // variant with switchable memory
    parameter bit HAS_CELL_IF = 1'b1 // variant with a cell interface
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [config_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [config_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [config_pkg::DATA_W-1:0] reg_rdata,
    // board straps
    input wire logic [3:0] latched_boot_mode,
    input wire logic interface_selection_switch,
    // memory routing
    output logic sbsram_area0_en,
    output logic sdram_area0_en,
    output logic sdram_area2_en,
    // interface choice for the rest of the board
    output logic serial_or_cell_interface_select
);
    config_pkg::reg_req_s req; // bundled bus request
    logic [4:0] strap_sync; // synchronised boot mode and switch
    logic wr_hit; // write to the configuration word
    logic load_pending; // first cycle after reset release
    logic next_load_pending;
    logic memory_type_select; // memory type select field
    logic next_memory_type_select;
    logic next_if_sel; // next interface select
    config_pkg::mem_route_s route; // registered routing
    config_pkg::mem_route_s next_route;

    assign req.rd = reg_rd;
    assign req.wr = reg_wr;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;

    // straps are pins: two flops before any logic looks at them
    pin_sync #(
        .WIDTH(5)
    ) u_strap_sync (
        .clk(clk),
        .pin_in({interface_selection_switch, latched_boot_mode}),
        .pin_out(strap_sync)
    );

    // bus decode and read-back
    config_reg_port u_port (
        .clk(clk),
        .rst(rst),
        .req(req),
        .mem_sel(memory_type_select),
        .if_sel(serial_or_cell_interface_select),
        .wr_hit(wr_hit),
        .rdata(reg_rdata)
    );

    // next state: boot load once after release, then software writes
    always_comb begin
        next_load_pending = 1'b0;
        next_memory_type_select = memory_type_select;
        next_if_sel = serial_or_cell_interface_select;
        if (load_pending) begin
            // async reset may only load constants, so the strap-derived
            // defaults are taken at the first edge after release
            next_memory_type_select = HAS_MEM_SELECT &
                config_pkg::sdram_boot(strap_sync[3:0]);
            // switch frozen here; no later path updates it
            next_if_sel = HAS_CELL_IF & strap_sync[4];
        end
        if (wr_hit && HAS_MEM_SELECT) begin
            // a write in the load cycle wins over the boot default
            next_memory_type_select =
                req.wdata[config_pkg::MEM_SEL_BIT];
        end
        // upper-bit writes have no target and are dropped
        if (load_pending) begin
            next_route = config_pkg::route_for(next_memory_type_select);
        end else begin
            next_route = config_pkg::route_for(next_memory_type_select);
        end
    end

    // registers; routing stays off until the boot load has settled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pending <= config_pkg::LOAD_PENDING_RESET;
            memory_type_select <= config_pkg::MEM_SEL_RESET;
            serial_or_cell_interface_select <= config_pkg::IF_SEL_RESET;
            route <= config_pkg::ROUTE_RESET;
        end else begin
            load_pending <= next_load_pending;
            memory_type_select <= next_memory_type_select;
            serial_or_cell_interface_select <= next_if_sel;
            route <= next_route;
        end
    end

    assign sbsram_area0_en = route.sbsram_area0_en;
    assign sdram_area0_en = route.sdram_area0_en;
    assign sdram_area2_en = route.sdram_area2_en;
endmodule : board_system_config
`default_nettype wire

//--- dv/board_config_monitor.sv
// port checker for the configuration register block
// assumes a bind into board_system_config with rst async active high
`timescale 1ns/10ps
`default_nettype none
module board_config_monitor #(
    parameter bit HAS_MEM_SELECT = 1'b1,
    parameter bit HAS_CELL_IF = 1'b1
) (
    // clock, reset and register bus
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // straps and routing outputs
    input wire logic [3:0] latched_boot_mode,
    input wire logic interface_selection_switch,
    input wire logic sbsram_area0_en,
    input wire logic sdram_area0_en,
    input wire logic sdram_area2_en,
    input wire logic serial_or_cell_interface_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // only the word at offset zero is mapped
    wire hit = reg_addr == 8'h00;
    // write that may move the memory routing
    wire wr_sel = HAS_MEM_SELECT && reg_wr && hit;
    AST_ROUTE_XOR:
        assert property (!$past(rst) |-> sbsram_area0_en != sdram_area0_en)
        else $error("both or no memory routed");
    AST_AREA2:
        assert property (sdram_area2_en == sdram_area0_en)
        else $error("area2 differs from area0");
    AST_WR_SDRAM:
        assert property (wr_sel && reg_wdata[0] |=> sdram_area0_en)
        else $error("select 1 not applied");
    AST_WR_SBSRAM:
        assert property (wr_sel && !reg_wdata[0] |=> sbsram_area0_en)
        else $error("select 0 not applied");
    AST_RD_WORD:
        assert property (reg_rd && hit |=> reg_rdata ==
            {30'h0, serial_or_cell_interface_select, sdram_area0_en})
        else $error("read word wrong");
    AST_RD_ZERO:
        assert property (!(reg_rd && hit) |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    AST_IF_HOLD:
        assert property (!$past(rst) && !$past(rst, 2) |->
            $stable(serial_or_cell_interface_select))
        else $error("interface select moved");
    AST_BOOT_LOAD:
        assert property ($past(rst) && !reg_wr |=> sdram_area0_en ==
            (HAS_MEM_SELECT &&
            ($past(latched_boot_mode) inside {4'h1, 4'h9})))
        else $error("boot default wrong");
    AST_IF_LOAD:
        assert property ($past(rst) |=> serial_or_cell_interface_select ==
            (HAS_CELL_IF && $past(interface_selection_switch)))
        else $error("interface capture wrong");
    COV_WR_RD: cover property (wr_sel ##1 reg_rd && hit);
    COV_BOOT9: cover property ($past(rst) && latched_boot_mode == 4'h9);
    COV_CELL: cover property (serial_or_cell_interface_select);
endmodule : board_config_monitor
bind board_system_config board_config_monitor #(
    .HAS_MEM_SELECT(HAS_MEM_SELECT), .HAS_CELL_IF(HAS_CELL_IF)) u_mon (.*);
`default_nettype wire

//--- dv/tb_board_system_config.sv
// self-checking bench for the configuration register block
// assumes the package compiled first and the port checker bound in
`timescale 1ns/10ps
`default_nettype none
module tb_board_system_config;
    // design inputs, valued at time zero
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, a;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] latched_boot_mode = 4'h0;
    logic interface_selection_switch = 1'b0;
    logic sbsram_area0_en, sdram_area0_en, sdram_area2_en;
    logic serial_or_cell_interface_select, ifs_nc, sb_nm;
    // expected selects and read words still owed
    logic mem_x = 1'b0, if_x = 1'b0, pend = 1'b0;
    logic [31:0] q[$];
    int n_errors = 0, total_checks = 0;
    always #50 clk = ~clk;
    board_system_config dut (.*);
    // variant without a cell interface shares every input
    board_system_config #(.HAS_CELL_IF(1'b0)) dut_no_cell (.*,
        .reg_rdata(), .sbsram_area0_en(), .sdram_area0_en(),
        .sdram_area2_en(), .serial_or_cell_interface_select(ifs_nc));
    // variant without a memory select: select stays 0, SBSRAM routed
    board_system_config #(.HAS_MEM_SELECT(1'b0)) dut_no_mem (.*,
        .reg_rdata(), .sbsram_area0_en(sb_nm), .sdram_area0_en(),
        .sdram_area2_en(), .serial_or_cell_interface_select());
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // one bus cycle; the model follows writes, reads note their word
    task automatic bus(logic wr, logic rd, logic [7:0] ad, logic [31:0] d);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= ad;
        reg_wdata <= d;
        if (wr && ad == 8'h00) mem_x = d[0];
        if (rd) q.push_back(ad == 8'h00 ? {30'h0, if_x, mem_x} : 32'h0);
        @(posedge clk);
    endtask : bus
    // idle cycle lets routing settle, then compare the main routing and interface-select levels, plus one output of each variant
    task automatic route;
        bus(0, 0, 8'h00, 32'h0);
        check("sbsram0", 32'(sbsram_area0_en), 32'(!mem_x));
        check("sdram0", 32'(sdram_area0_en), 32'(mem_x));
        check("sdram2", 32'(sdram_area2_en), 32'(mem_x));
        check("ifsel", 32'(serial_or_cell_interface_select), 32'(if_x));
        check("ifsel_nc", 32'(ifs_nc), 32'h0);
        check("sbsram0_nm", 32'(sb_nm), 32'h1);
    endtask : route
    // read monitor: one owed word per read strobe taken
    always @(posedge clk) begin
        if (pend) check("rdata", reg_rdata, q.pop_front());
        pend = reg_rd;
    end
    // every boot code through a reset, then writes and unmapped hits
    initial begin
        void'($urandom(91));
        for (int c = 0; c < 16; c++) begin
            latched_boot_mode <= 4'(c);
            interface_selection_switch <= 1'($urandom);
            rst <= 1'b1;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            mem_x = (c == 1 || c == 9);
            if_x = interface_selection_switch;
            repeat (2) @(posedge clk);
            // straps moving after release must change nothing
            latched_boot_mode <= ~latched_boot_mode;
            interface_selection_switch <= ~interface_selection_switch;
            route;
            bus(0, 1, 8'h00, 32'h0);
            // software would reprogram its memory interface here
            bus(1, 0, 8'h00, {31'($urandom), !mem_x});
            bus(0, 1, 8'h00, 32'h0);
            route;
            a = 8'($urandom_range(255, 1));
            bus(1, 0, a, {31'($urandom), !mem_x});
            bus(0, 1, a, 32'h0);
            bus(0, 1, 8'h00, 32'h0);
            route;
        end
        final_report;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule : tb_board_system_config
`default_nettype wire
